// >>> lsm_pkg.sv
// constants, types and shedding table for the load shed energy manager
// What this block does
// - 240 V 50 A service disables management and closes all six relays.
// - Otherwise shed loads while current exceeds the active shore or generator limit.
// - Generator limit is 45 A gas or 60 A diesel, set by installer.
// - After power comes up, all loads stay off for two minutes.
// - Load meter shows rotating segments during the start-up delay.
// - After the delay, loads switch on one at a time, one second apart.
// - Line plus generator sense: generator mode, managed, current shown, indicators lit.
// - Generator sense overrides every other source indication except absence of both lines.
// - Line present without generator or 240 V sense means 30 A shore, managed.
// - 20 A shore is chosen only by a press of service select or a write of the press bit in the control register.
// - 240 V mode blanks the meter and lights 50 A and power indicators.
// - First overload turns off the first load of the shedding order.
// - Each shed stores the current drop as that load's learned value.
// - Keep shedding in order until at or under limit or all six are off.
// - Learned value is overwritten at every shed of that load.
// - Restore last shed load only with headroom at least its learned value.
// - A shed load stays off at least two minutes.
// - Six relay outputs: one to four line loads, five and six low voltage.
// - Generator rating jumper fitted gives 45 A, absent gives 60 A.
// - Fresh shore power always starts in 30 A mode.
// - Another press in 20 A mode returns to 30 A mode.
// - Three jumpers pick one of eight fixed relay shedding sequences.
package lsm_pkg;
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned TICK_MS = 100;
   localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned STARTUP_S = 120;
   localparam int unsigned STEP_S = 1;
   localparam int unsigned HOLD_S = 120;
   localparam int unsigned TICKS_PER_S = 1000 / TICK_MS;
   localparam logic [10:0] STARTUP_TICKS = 11'(STARTUP_S * TICKS_PER_S);
   localparam logic [10:0] STEP_TICKS = 11'(STEP_S * TICKS_PER_S);
   localparam logic [10:0] HOLD_TICKS = 11'(HOLD_S * TICKS_PER_S);
   localparam logic [7:0] LIMIT_SHORE30 = 8'h1E;
   localparam logic [7:0] LIMIT_SHORE20 = 8'h14;
   localparam logic [7:0] LIMIT_GAS = 8'h2D;
   localparam logic [7:0] LIMIT_DIESEL = 8'h3C;
   localparam int unsigned NUM_LOADS = 6;
   localparam logic [2:0] LAST_POS = 3'h5;
   localparam logic [2:0] ALL_SHED = 3'h6;
   localparam logic [5:0] ALL_ON = 6'h3F;
   localparam logic [5:0] REG_STATUS = 6'h00;
   localparam logic [5:0] REG_CURRENT = 6'h04;
   localparam logic [5:0] REG_CONTROL = 6'h08;
   localparam logic [5:0] REG_LEARN0 = 6'h0C;
   localparam logic [5:0] REG_LEARN5 = 6'h20;
   localparam int unsigned ST_MODE_LSB = 8;
   localparam int unsigned ST_STATE_LSB = 12;
   localparam int unsigned ST_SHED_LSB = 16;
   localparam int unsigned ST_LOW_BIT = 20;
   localparam int unsigned CUR_LIMIT_LSB = 8;
   localparam int unsigned CTL_PRESS_BIT = 0;
   typedef enum logic [2:0] {
      MODE_NONE = 3'b000,
      MODE_GEN = 3'b001,
      MODE_SHORE30 = 3'b010,
      MODE_SHORE20 = 3'b011,
      MODE_FULL240 = 3'b100
   } lsm_mode_e;
   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_STARTUP = 3'b001,
      ST_RAMP = 3'b010,
      ST_RUN = 3'b011,
      ST_SETTLE = 3'b100,
      ST_FULL = 3'b101
   } lsm_state_e;
   // relay index (0 based) shed at position pos for jumper column col
   function automatic logic [2:0] shed_relay(input logic [2:0] col, input logic [2:0] pos);
      logic [17:0] seq;
      case (col)
         3'h0: seq = {3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
         3'h1: seq = {3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h3};
         3'h2: seq = {3'h0, 3'h1, 3'h4, 3'h5, 3'h2, 3'h3};
         3'h3: seq = {3'h0, 3'h4, 3'h5, 3'h1, 3'h2, 3'h3};
         3'h4: seq = {3'h4, 3'h5, 3'h0, 3'h1, 3'h2, 3'h3};
         3'h5: seq = {3'h0, 3'h1, 3'h2, 3'h4, 3'h3, 3'h5};
         3'h6: seq = {3'h0, 3'h1, 3'h4, 3'h2, 3'h5, 3'h3};
         default: seq = {3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h3};
      endcase
      shed_relay = seq[pos * 3 +: 3];
   endfunction
endpackage

// >>> lsm_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module lsm_sync #(
   parameter int unsigned W = 1
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] pin_sync
);
   logic [W-1:0] meta;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         meta <= '0;
         pin_sync <= '0;
      end else begin
         meta <= pin_in;
         pin_sync <= meta;
      end
   end
endmodule

// >>> lsm_tick.sv
// divider giving the slow decision tick as a one-cycle enable
`timescale 1ns/1ps
module lsm_tick #(
   parameter int unsigned PERIOD = 2
) (
   input wire logic ref_clk,
   input wire logic reset,
   output logic tick
);
   logic [31:0] count;
   logic [31:0] next_count;
   logic next_tick;
   always_comb begin
      next_tick = 1'b0;
      next_count = count + 32'h1;
      if (count >= 32'(PERIOD - 1)) begin
         next_count = '0;
         next_tick = 1'b1;
      end
   end
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         count <= '0;
         tick <= 1'b0;
      end else begin
         count <= next_count;
         tick <= next_tick;
      end
   end
endmodule

// >>> lsm_energy_manager.sv
// load shed energy manager with source detection, start-up and avalon registers
`timescale 1ns/1ps
module lsm_energy_manager #(
   parameter int unsigned TICK_CYCLES = lsm_pkg::TICK_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic line_one_present,
   input wire logic line_two_present,
   input wire logic service_240_sense,
   input wire logic generator_run_sense,
   input wire logic generator_rating_jumper,
   input wire logic shed_order_select_a,
   input wire logic shed_order_select_b,
   input wire logic shed_order_select_c,
   input wire logic service_select_button,
   input wire logic [7:0] current_sample,
   input wire logic current_valid,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [5:0] relay_drive,
   output logic [7:0] meter_value,
   output logic meter_blank,
   output logic meter_rotate,
   output logic ind_generator,
   output logic ind_service_50a,
   output logic ind_service_30_20a,
   output logic [5:0] power_status
);
   logic [8:0] pins_sync;
   logic l1, l2, s240, gen_run, gen_fitted, sel_a, sel_b, sel_c, button;
   logic tick;
   lsm_sync #(.W(9)) u_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .pin_in({service_select_button, shed_order_select_c, shed_order_select_b,
         shed_order_select_a, generator_rating_jumper, generator_run_sense,
         service_240_sense, line_two_present, line_one_present}),
      .pin_sync(pins_sync)
   );
   assign {button, sel_c, sel_b, sel_a, gen_fitted, gen_run, s240, l2, l1} = pins_sync;
   lsm_tick #(.PERIOD(TICK_CYCLES)) u_tick (
      .ref_clk(ref_clk),
      .reset(reset),
      .tick(tick)
   );

   // control state
   lsm_pkg::lsm_state_e state, next_state;
   logic low_thr, next_low_thr;
   logic button_q;
   logic [10:0] timer, next_timer;
   logic [2:0] ramp_pos, next_ramp_pos;
   logic [2:0] shed_count, next_shed_count;
   logic [2:0] act_idx, next_act_idx;
   logic act_shed, next_act_shed;
   logic [5:0] relay, next_relay;
   logic [7:0] pre_cur, next_pre_cur;
   logic [7:0] cur, next_cur;
   logic [7:0] learned [0:5];
   logic [7:0] next_learned [0:5];
   logic [10:0] hold [0:5];
   logic [10:0] next_hold [0:5];
   lsm_pkg::lsm_mode_e mode;
   logic [7:0] limit;
   logic [2:0] col, shed_idx, last_idx;
   logic press, sw_press, over, under, shed_go, restore_go;
   logic [7:0] headroom;

   // source detection, generator first
   always_comb begin
      if (!l1 && !l2) begin
         mode = lsm_pkg::MODE_NONE;
      end else if (gen_run) begin
         mode = lsm_pkg::MODE_GEN;
      end else if (s240) begin
         mode = lsm_pkg::MODE_FULL240;
      end else if (low_thr) begin
         mode = lsm_pkg::MODE_SHORE20;
      end else begin
         mode = lsm_pkg::MODE_SHORE30;
      end
   end

   always_comb begin
      case (mode)
         lsm_pkg::MODE_GEN: limit = gen_fitted ? lsm_pkg::LIMIT_GAS
            : lsm_pkg::LIMIT_DIESEL;
         lsm_pkg::MODE_SHORE20: limit = lsm_pkg::LIMIT_SHORE20;
         default: limit = lsm_pkg::LIMIT_SHORE30;
      endcase
   end

   assign col = {~sel_a, ~sel_b, ~sel_c};
   assign shed_idx = lsm_pkg::shed_relay(col, shed_count);
   assign last_idx = lsm_pkg::shed_relay(col, shed_count - 3'h1);
   assign press = button & ~button_q;
   assign over = cur > limit;
   assign under = cur < limit;
   assign headroom = limit - cur;
   assign shed_go = (state == lsm_pkg::ST_RUN) && (mode != lsm_pkg::MODE_FULL240) && tick
      && over && (mode != lsm_pkg::MODE_NONE) && (shed_count < lsm_pkg::ALL_SHED);
   assign restore_go = (state == lsm_pkg::ST_RUN) && (mode != lsm_pkg::MODE_FULL240) && tick
      && !over && under && (shed_count != 3'h0) && (headroom >= learned[last_idx])
      && (mode != lsm_pkg::MODE_NONE) && (hold[last_idx] == 11'h0);

   always_comb begin
      next_state = state;
      next_timer = timer;
      next_ramp_pos = ramp_pos;
      next_shed_count = shed_count;
      next_act_idx = act_idx;
      next_act_shed = act_shed;
      next_relay = relay;
      next_pre_cur = pre_cur;
      next_cur = current_valid ? current_sample : cur;
      next_low_thr = low_thr;
      for (int i = 0; i < lsm_pkg::NUM_LOADS; i++) begin
         next_learned[i] = learned[i];
         next_hold[i] = (tick && hold[i] != 11'h0) ? hold[i] - 11'h1 : hold[i];
      end
      if (mode == lsm_pkg::MODE_NONE) begin
         next_low_thr = 1'b0;
      end else if ((press || sw_press) && (mode == lsm_pkg::MODE_SHORE30
            || mode == lsm_pkg::MODE_SHORE20)) begin
         next_low_thr = ~low_thr;
      end
      case (state)
         lsm_pkg::ST_OFF: begin
            next_relay = '0;
            next_shed_count = '0;
            if (mode != lsm_pkg::MODE_NONE) begin
               next_state = lsm_pkg::ST_STARTUP;
               next_timer = lsm_pkg::STARTUP_TICKS;
            end
         end
         lsm_pkg::ST_STARTUP: begin
            next_relay = '0;
            if (tick) begin
               next_timer = timer - 11'h1;
               if (timer <= 11'h1) begin
                  next_relay[0] = 1'b1;
                  next_ramp_pos = 3'h1;
                  next_timer = lsm_pkg::STEP_TICKS;
                  next_state = lsm_pkg::ST_RAMP;
               end
            end
         end
         lsm_pkg::ST_RAMP: begin
            if (tick) begin
               next_timer = timer - 11'h1;
               if (timer <= 11'h1) begin
                  next_relay[ramp_pos] = 1'b1;
                  next_ramp_pos = ramp_pos + 3'h1;
                  next_timer = lsm_pkg::STEP_TICKS;
                  if (ramp_pos == lsm_pkg::LAST_POS) begin
                     next_state = lsm_pkg::ST_RUN;
                  end
               end
            end
         end
         lsm_pkg::ST_RUN: begin
            if (mode == lsm_pkg::MODE_FULL240) begin
               next_relay = lsm_pkg::ALL_ON;
               next_shed_count = '0;
               next_state = lsm_pkg::ST_FULL;
            end else if (shed_go) begin
               next_relay[shed_idx] = 1'b0;
               next_pre_cur = cur;
               next_act_idx = shed_idx;
               next_act_shed = 1'b1;
               next_hold[shed_idx] = lsm_pkg::HOLD_TICKS;
               next_shed_count = shed_count + 3'h1;
               next_timer = lsm_pkg::STEP_TICKS;
               next_state = lsm_pkg::ST_SETTLE;
            end else if (restore_go) begin
               next_relay[last_idx] = 1'b1;
               next_act_idx = last_idx;
               next_act_shed = 1'b0;
               next_shed_count = shed_count - 3'h1;
               next_timer = lsm_pkg::STEP_TICKS;
               next_state = lsm_pkg::ST_SETTLE;
            end
         end
         lsm_pkg::ST_SETTLE: begin
            if (tick) begin
               next_timer = timer - 11'h1;
               if (timer <= 11'h1) begin
                  if (act_shed) begin
                     next_learned[act_idx] = (pre_cur > cur) ? pre_cur - cur
                        : 8'h00;
                  end
                  next_state = lsm_pkg::ST_RUN;
               end
            end
         end
         lsm_pkg::ST_FULL: begin
            next_relay = lsm_pkg::ALL_ON;
            next_shed_count = '0;
            if (mode != lsm_pkg::MODE_FULL240) begin
               next_state = lsm_pkg::ST_RUN;
            end
         end
         default: begin
            next_state = lsm_pkg::ST_OFF;
         end
      endcase
      if (mode == lsm_pkg::MODE_NONE) begin
         next_state = lsm_pkg::ST_OFF;
         next_relay = '0;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state <= lsm_pkg::ST_OFF;
         timer <= '0;
         ramp_pos <= '0;
         shed_count <= '0;
         act_idx <= '0;
         act_shed <= 1'b0;
         relay <= '0;
         pre_cur <= '0;
         cur <= '0;
         low_thr <= 1'b0;
         button_q <= 1'b0;
         for (int i = 0; i < lsm_pkg::NUM_LOADS; i++) begin
            learned[i] <= '0;
            hold[i] <= '0;
         end
      end else begin
         state <= next_state;
         timer <= next_timer;
         ramp_pos <= next_ramp_pos;
         shed_count <= next_shed_count;
         act_idx <= next_act_idx;
         act_shed <= next_act_shed;
         relay <= next_relay;
         pre_cur <= next_pre_cur;
         cur <= next_cur;
         low_thr <= next_low_thr;
         button_q <= button;
         for (int i = 0; i < lsm_pkg::NUM_LOADS; i++) begin
            learned[i] <= next_learned[i];
            hold[i] <= next_hold[i];
         end
      end
   end

   // outputs and indications
   assign relay_drive = relay;
   assign meter_value = cur;
   assign meter_rotate = (state == lsm_pkg::ST_STARTUP);
   assign meter_blank = (mode == lsm_pkg::MODE_FULL240);
   assign ind_generator = (mode == lsm_pkg::MODE_GEN);
   assign ind_service_50a = (mode == lsm_pkg::MODE_FULL240);
   assign ind_service_30_20a = (mode == lsm_pkg::MODE_SHORE30);
   assign power_status = (mode == lsm_pkg::MODE_GEN || mode == lsm_pkg::MODE_FULL240)
      ? lsm_pkg::ALL_ON : relay;

   // avalon slave: one wait state per access
   logic ack, next_ack;
   logic [31:0] rdata, next_rdata;
   logic [2:0] learn_sel;
   assign learn_sel = 3'((avs_address - lsm_pkg::REG_LEARN0) >> 2);
   assign avs_waitrequest = (avs_read || avs_write) && !ack;
   assign avs_readdata = rdata;
   assign sw_press = avs_write && ack && (avs_address == lsm_pkg::REG_CONTROL)
      && avs_byteenable[0] && avs_writedata[lsm_pkg::CTL_PRESS_BIT];

   always_comb begin
      next_ack = (avs_read || avs_write) && !ack;
      next_rdata = rdata;
      if (avs_read && !ack) begin
         next_rdata = '0;
         if (avs_address == lsm_pkg::REG_STATUS) begin
            next_rdata[5:0] = relay;
            next_rdata[lsm_pkg::ST_MODE_LSB +: 3] = mode;
            next_rdata[lsm_pkg::ST_STATE_LSB +: 3] = state;
            next_rdata[lsm_pkg::ST_SHED_LSB +: 3] = shed_count;
            next_rdata[lsm_pkg::ST_LOW_BIT] = low_thr;
         end else if (avs_address == lsm_pkg::REG_CURRENT) begin
            next_rdata[7:0] = cur;
            next_rdata[lsm_pkg::CUR_LIMIT_LSB +: 8] = limit;
         end else if (avs_address >= lsm_pkg::REG_LEARN0
               && avs_address <= lsm_pkg::REG_LEARN5 && avs_address[1:0] == 2'h0) begin
            next_rdata[7:0] = learned[learn_sel];
         end
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ack <= 1'b0;
         rdata <= '0;
      end else begin
         ack <= next_ack;
         rdata <= next_rdata;
      end
   end

   // checks
   property p_full_all_on;
      @(posedge ref_clk) disable iff (reset)
      (state == lsm_pkg::ST_FULL) |-> (relay_drive == lsm_pkg::ALL_ON
         && (meter_blank || !$stable(mode)));
   endproperty
   a_full_all_on: assert property (p_full_all_on)
      else $error("240 V mode with a relay open");
   property p_startup_off;
      @(posedge ref_clk) disable iff (reset)
      (state == lsm_pkg::ST_STARTUP) |-> (relay_drive == 6'h00 && meter_rotate);
   endproperty
   a_startup_off: assert property (p_startup_off)
      else $error("load on during start-up delay");
   property p_shed_cause;
      @(posedge ref_clk) disable iff (reset)
      shed_go |=> (state == lsm_pkg::ST_SETTLE) && act_shed
         && ($countones(relay_drive) == $countones($past(relay_drive)) - 1);
   endproperty
   a_shed_cause: assert property (p_shed_cause)
      else $error("shed did not open exactly one relay");
   property p_shed_needs_over;
      @(posedge ref_clk) disable iff (reset)
      ($fell(act_shed) || (act_shed && $changed(act_idx))) || !(state == lsm_pkg::ST_SETTLE
         && $past(state) == lsm_pkg::ST_RUN && act_shed) || $past(over);
   endproperty
   a_shed_needs_over: assert property (p_shed_needs_over)
      else $error("shed without overload");
   property p_restore_hold;
      @(posedge ref_clk) disable iff (reset)
      (state == lsm_pkg::ST_SETTLE && $past(state) == lsm_pkg::ST_RUN && !act_shed)
         |-> (hold[act_idx] == 11'h0) && ($past(headroom) >= learned[act_idx])
         && relay_drive[act_idx];
   endproperty
   a_restore_hold: assert property (p_restore_hold)
      else $error("restore without headroom or before hold ended");
   property p_learn;
      @(posedge ref_clk) disable iff (reset)
      (state == lsm_pkg::ST_SETTLE && act_shed && tick && timer <= 11'h1 && pre_cur > cur)
         |=> (learned[$past(act_idx)] == $past(pre_cur) - $past(cur));
   endproperty
   a_learn: assert property (p_learn)
      else $error("learned current not the measured drop");
   property p_gen_limit;
      @(posedge ref_clk) disable iff (reset)
      (gen_run && (l1 || l2)) |-> ind_generator && power_status == lsm_pkg::ALL_ON
         && (limit == (gen_fitted ? lsm_pkg::LIMIT_GAS : lsm_pkg::LIMIT_DIESEL));
   endproperty
   a_gen_limit: assert property (p_gen_limit)
      else $error("generator mode or limit wrong");
   property p_ramp_step;
      @(posedge ref_clk) disable iff (reset)
      (state == lsm_pkg::ST_RAMP && $changed(relay_drive))
         |-> $countones(relay_drive) == $countones($past(relay_drive)) + 1;
   endproperty
   a_ramp_step: assert property (p_ramp_step)
      else $error("ramp closed more than one relay");
   property p_count_bound;
      @(posedge ref_clk) disable iff (reset)
      shed_count <= lsm_pkg::ALL_SHED;
   endproperty
   a_count_bound: assert property (p_count_bound)
      else $error("shed count beyond six");
endmodule

// >>> lsm_energy_manager_test.sv
// self-checking testbench for the load shed energy manager
`timescale 1ns/1ps
module lsm_energy_manager_test;
   localparam int unsigned TK = 4;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic line_one_present = 1'b0, line_two_present = 1'b0;
   logic service_240_sense = 1'b0, generator_run_sense = 1'b0;
   logic generator_rating_jumper = 1'b1, service_select_button = 1'b0;
   logic [2:0] shed_sel = 3'h3;
   logic [7:0] current_sample = 8'h00;
   logic current_valid = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0, avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, rd;
   logic avs_waitrequest, meter_blank, meter_rotate;
   logic ind_generator, ind_service_50a, ind_service_30_20a;
   logic [5:0] relay_drive, power_status;
   logic [7:0] meter_value;
   int num_errors = 0;
   int total_checks = 0;

   lsm_energy_manager #(.TICK_CYCLES(TK)) lsm_energy_manager_inst (
      .ref_clk(ref_clk), .reset(reset),
      .line_one_present(line_one_present), .line_two_present(line_two_present),
      .service_240_sense(service_240_sense), .generator_run_sense(generator_run_sense),
      .generator_rating_jumper(generator_rating_jumper),
      .shed_order_select_a(shed_sel[2]), .shed_order_select_b(shed_sel[1]),
      .shed_order_select_c(shed_sel[0]), .service_select_button(service_select_button),
      .current_sample(current_sample), .current_valid(current_valid),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .relay_drive(relay_drive), .meter_value(meter_value), .meter_blank(meter_blank),
      .meter_rotate(meter_rotate), .ind_generator(ind_generator),
      .ind_service_50a(ind_service_50a), .ind_service_30_20a(ind_service_30_20a),
      .power_status(power_status)
   );

   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // one avalon access; entered just after a rising edge
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0 && n < 100) begin
         @(posedge ref_clk);
         n++;
      end
      if (n == 100) check(32'h1, 32'h0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic cur(input logic [7:0] v);
      current_sample <= v;
      current_valid <= 1'b1;
      @(posedge ref_clk);
      current_valid <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic ticks(input int n);
      repeat (n * TK) @(posedge ref_clk);
   endtask

   // waits up to n ticks for the relay pattern, then compares it
   task automatic wait_relays(input logic [5:0] v, input int n);
      int k;
      k = 0;
      @(negedge ref_clk);
      while (relay_drive !== v && k < n * TK) begin
         @(negedge ref_clk);
         k++;
      end
      check(32'(relay_drive), 32'(v));
      @(posedge ref_clk);
   endtask

   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge ref_clk);
      num_errors++;
      wrap_up();
   end

   initial begin
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      line_one_present <= 1'b1;
      line_two_present <= 1'b1;
      ticks(1000);
      @(negedge ref_clk);
      check(32'(relay_drive), 32'h0);
      check(32'(meter_rotate), 32'h1);
      check(32'(ind_service_30_20a), 32'h1);
      @(posedge ref_clk);
      wait_relays(6'h01, 300);
      ticks(5);
      wait_relays(6'h01, 0);
      ticks(7);
      wait_relays(6'h03, 0);
      wait_relays(6'h3F, 60);
      bus(1'b0, lsm_pkg::REG_STATUS, 32'h0);
      check(32'(rd[10:8]), 32'h2);
      bus(1'b0, lsm_pkg::REG_CURRENT, 32'h0);
      check(32'(rd[15:8]), 32'h1E);
      bus(1'b0, 6'h3C, 32'h0);
      check(rd, 32'h0);
      $display("test done: startup and ramp");
      service_select_button <= 1'b1;
      ticks(1);
      service_select_button <= 1'b0;
      ticks(2);
      bus(1'b0, lsm_pkg::REG_CURRENT, 32'h0);
      check(32'(rd[15:8]), 32'h14);
      bus(1'b1, lsm_pkg::REG_CONTROL, 32'h1);
      ticks(2);
      bus(1'b0, lsm_pkg::REG_CURRENT, 32'h0);
      check(32'(rd[15:8]), 32'h1E);
      $display("test done: service select");
      cur(8'h28);
      wait_relays(6'h37, 30);
      cur(8'h19);
      ticks(14);
      bus(1'b0, 6'h18, 32'h0);
      check(rd, 32'hF);
      cur(8'h23);
      wait_relays(6'h33, 30);
      cur(8'h14);
      ticks(14);
      bus(1'b0, 6'h14, 32'h0);
      check(rd, 32'hF);
      cur(8'h0A);
      ticks(100);
      wait_relays(6'h33, 0);
      wait_relays(6'h37, 1300);
      cur(8'h28);
      wait_relays(6'h33, 30);
      cur(8'h16);
      ticks(14);
      bus(1'b0, 6'h14, 32'h0);
      check(rd, 32'h12);
      $display("test done: shed and restore");
      generator_run_sense <= 1'b1;
      service_240_sense <= 1'b1;
      ticks(3);
      cur(8'h21);
      @(negedge ref_clk);
      check(32'(ind_generator), 32'h1);
      check(32'(ind_service_50a), 32'h0);
      check(32'(power_status), 32'h3F);
      check(32'(meter_value), 32'h21);
      @(posedge ref_clk);
      bus(1'b0, lsm_pkg::REG_CURRENT, 32'h0);
      check(32'(rd[15:8]), 32'h2D);
      generator_rating_jumper <= 1'b0;
      ticks(3);
      bus(1'b0, lsm_pkg::REG_CURRENT, 32'h0);
      check(32'(rd[15:8]), 32'h3C);
      $display("test done: generator");
      generator_run_sense <= 1'b0;
      wait_relays(6'h3F, 1300);
      @(negedge ref_clk);
      check(32'(meter_blank), 32'h1);
      check(32'(ind_service_50a), 32'h1);
      check(32'(power_status), 32'h3F);
      @(posedge ref_clk);
      bus(1'b0, lsm_pkg::REG_STATUS, 32'h0);
      check(32'(rd[10:8]), 32'h4);
      $display("test done: full service");
      wrap_up();
   end
endmodule
